/* File: i2c_slave_map.svh */
// Register offsets, field positions, reset values and timing counts of the serial slave
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH

`define OFS_CTRL0 3'h0
`define OFS_CTRL1 3'h1
`define OFS_DATA 3'h2
`define OFS_OWN_ADDR 3'h3
`define OFS_TIMEOUT 3'h4

`define CTRL0_IRQ_EN_BIT 0
`define CTRL0_IF_EN_BIT 1
`define CTRL0_IRQ_FLAG_BIT 2
`define CTRL0_WMASK 8'h03

`define CTRL1_DONE_BIT 7
`define CTRL1_MATCH_BIT 6
`define CTRL1_BUSY_BIT 5
`define CTRL1_XMIT_BIT 4
`define CTRL1_ACKOUT_BIT 3
`define CTRL1_DIR_BIT 2
`define CTRL1_WAKE_BIT 1
`define CTRL1_ACKIN_BIT 0
`define CTRL1_WMASK 8'h1a

`define TOC_EN_BIT 7
`define TOC_FLAG_BIT 6
`define TOC_SEL_MSB 5

`define CTRL0_RESET 8'h00
`define CTRL1_RESET 8'h81
`define DATA_RESET 8'h00
`define OWN_ADDR_RESET 8'h00
`define TOC_RESET 8'h00

`define TIMEOUT_UNIT_SUB 5
`define BYTE_BITS 4'h8

`endif

/* File: i2c_slave_pkg.sv */
// Types shared by the serial slave modules
`default_nettype none

package i2c_slave_pkg;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_HOLD = 9'h008,
        ST_RX = 9'h010,
        ST_RX_ACK = 9'h020,
        ST_TX = 9'h040,
        ST_TX_ACK = 9'h080,
        ST_WAIT = 9'h100
    } link_state_t;

    typedef struct packed {
        link_state_t st;
        logic scl_prev;
        logic sda_prev;
        logic sub_prev;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] data;
        logic [7:0] own_addr;
        logic [7:0] toc;
        logic to_run;
        logic [11:0] to_cnt;
        logic irq_line;
        logic sda_oe_n;
        logic scl_oe_n;
        logic pin_low;
        logic [7:0] rdata;
    } slave_state_t;

endpackage : i2c_slave_pkg

`default_nettype wire

/* File: pin_sync.sv */
// Two-stage synchroniser for inputs from outside the system clock
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    always_comb begin
        next_s = s;
        if (ce_in) begin
            next_s.meta = async_in;
            next_s.stable = s.meta;
        end
    end

    // Idle bus lines are high, so reset to high avoids false edges
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;

endmodule : pin_sync

`default_nettype wire

/* File: i2c_slave.sv */
// Two-wire bus slave with address match, byte transfer, clock hold and bus time-out
//
// Our own choices: the address-and-strobe port and the register offsets.
`include "i2c_slave_map.svh"
`default_nettype none

// Behaviour
// - START sets the bus busy flag
// - STOP clears the bus busy flag
// - Shift seven address bits MSB first, compare
// - Address match sets flag and interrupt
// - Eighth bit captured as direction flag
// - Direction one means slave transmits
// - Slave acknowledges its matching address
// - Bytes are eight bits, MSB first
// - Receiver acknowledges low on ninth clock
// - Ninth clock carries the transmit acknowledge bit
// - Release data line on master no-acknowledge
// - Received byte lands in data register
// - Byte flag clears in transfer, sets after
// - One interrupt from match, byte, time-out
// - Time-out counts from match, restarts, halts
// - Time-out stops, clears enable, flags, interrupts
// - Time-out resets logic and second control
// - Time-out is select plus one, times 32
module i2c_slave
    import i2c_slave_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic CE_IN,
    input wire logic [2:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_N_OUT,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    input wire logic SUB_CLK_IN,
    output logic IRQ_OUT
);

    slave_state_t s;
    slave_state_t next_s;
    logic [2:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic sub_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic sub_rise;
    logic if_en;
    logic addr_hit;
    logic [11:0] to_limit;
    logic timeout_hit;

    pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .ce_in(CE_IN),
        .async_in({SUB_CLK_IN, SDA_IN, SCL_IN}),
        .sync_out(pins_sync)
    );

    assign scl_s = pins_sync[0];
    assign sda_s = pins_sync[1];
    assign sub_s = pins_sync[2];
    assign scl_rise = scl_s && !s.scl_prev;
    assign scl_fall = !scl_s && s.scl_prev;
    assign start_ev = scl_s && s.scl_prev && !sda_s && s.sda_prev;
    assign stop_ev = scl_s && s.scl_prev && sda_s && !s.sda_prev;
    assign sub_rise = sub_s && !s.sub_prev;
    assign if_en = s.ctrl0[`CTRL0_IF_EN_BIT];
    // seven address bits against own address
    assign addr_hit = s.shift[7:1] == s.own_addr[7:1];
    // select k gives k plus one units
    assign to_limit = {({1'b0, s.toc[`TOC_SEL_MSB:0]} + 7'h01), `TIMEOUT_UNIT_SUB'(0)};
    assign timeout_hit = s.to_run && (s.to_cnt >= to_limit);

    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;
        if (CE_IN) begin
            next_s.scl_prev = scl_s;
            next_s.sda_prev = sda_s;
            next_s.sub_prev = sub_s;

            if (RD_IN) begin
                case (ADDR_IN)
                    `OFS_CTRL0: next_s.rdata = s.ctrl0;
                    `OFS_CTRL1: next_s.rdata = s.ctrl1;
                    `OFS_DATA: next_s.rdata = s.data;
                    `OFS_OWN_ADDR: next_s.rdata = {s.own_addr[7:1], 1'b0};
                    `OFS_TIMEOUT: next_s.rdata = s.toc;
                    default: next_s.rdata = 8'h00;
                endcase
            end

            if (WR_IN) begin
                case (ADDR_IN)
                    `OFS_CTRL0: begin
                        next_s.ctrl0 = (WDATA_IN & `CTRL0_WMASK)
                            | (s.ctrl0 & WDATA_IN & (8'h01 << `CTRL0_IRQ_FLAG_BIT));
                    end
                    `OFS_CTRL1: begin
                        next_s.ctrl1 = (s.ctrl1 & ~`CTRL1_WMASK) | (WDATA_IN & `CTRL1_WMASK);
                    end
                    `OFS_DATA: next_s.data = WDATA_IN;
                    `OFS_OWN_ADDR: next_s.own_addr = {WDATA_IN[7:1], 1'b0};
                    // flag is cleared only by software
                    `OFS_TIMEOUT: next_s.toc = WDATA_IN;
                    default: next_s.toc = next_s.toc;
                endcase
            end

            case (s.st)
                ST_IDLE: begin
                    next_s.sda_oe_n = 1'b1;
                    next_s.scl_oe_n = 1'b1;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], sda_s};
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                    end else if (scl_fall && s.bit_cnt == `BYTE_BITS) begin
                        if (addr_hit) begin
                            next_s.ctrl1[`CTRL1_MATCH_BIT] = 1'b1;
                            next_s.ctrl0[`CTRL0_IRQ_FLAG_BIT] = 1'b1;
                            next_s.ctrl1[`CTRL1_DIR_BIT] = s.shift[0];
                            next_s.sda_oe_n = 1'b0;
                            next_s.to_run = s.toc[`TOC_EN_BIT];
                            next_s.to_cnt = 12'h000;
                            next_s.st = ST_ADDR_ACK;
                        end else begin
                            next_s.st = ST_WAIT;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_s.sda_oe_n = 1'b1;
                        next_s.scl_oe_n = 1'b0;
                        next_s.st = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (s.ctrl1[`CTRL1_XMIT_BIT] && WR_IN && ADDR_IN == `OFS_DATA) begin
                        next_s.shift = WDATA_IN;
                        next_s.sda_oe_n = WDATA_IN[7];
                        next_s.scl_oe_n = 1'b1;
                        next_s.bit_cnt = 4'h0;
                        next_s.ctrl1[`CTRL1_DONE_BIT] = 1'b0;
                        next_s.ctrl1[`CTRL1_MATCH_BIT] = 1'b0;
                        next_s.st = ST_TX;
                    end else if (!s.ctrl1[`CTRL1_XMIT_BIT] && RD_IN && ADDR_IN == `OFS_DATA) begin
                        next_s.scl_oe_n = 1'b1;
                        next_s.bit_cnt = 4'h0;
                        next_s.ctrl1[`CTRL1_DONE_BIT] = 1'b0;
                        next_s.ctrl1[`CTRL1_MATCH_BIT] = 1'b0;
                        next_s.st = ST_RX;
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], sda_s};
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                    end else if (scl_fall && s.bit_cnt == `BYTE_BITS) begin
                        next_s.data = s.shift;
                        next_s.ctrl1[`CTRL1_DONE_BIT] = 1'b1;
                        next_s.ctrl0[`CTRL0_IRQ_FLAG_BIT] = 1'b1;
                        // transmit acknowledge bit on ninth clock
                        next_s.sda_oe_n = s.ctrl1[`CTRL1_ACKOUT_BIT];
                        next_s.st = ST_RX_ACK;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        next_s.sda_oe_n = 1'b1;
                        next_s.scl_oe_n = 1'b0;
                        next_s.st = ST_HOLD;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                        if (s.bit_cnt == `BYTE_BITS - 4'h1) begin
                            next_s.sda_oe_n = 1'b1;
                            next_s.st = ST_TX_ACK;
                        end else begin
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_oe_n = s.shift[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        next_s.ctrl1[`CTRL1_ACKIN_BIT] = sda_s;
                    end else if (scl_fall) begin
                        next_s.ctrl1[`CTRL1_DONE_BIT] = 1'b1;
                        next_s.ctrl0[`CTRL0_IRQ_FLAG_BIT] = 1'b1;
                        // no acknowledge releases the data line
                        if (s.ctrl1[`CTRL1_ACKIN_BIT]) begin
                            next_s.st = ST_WAIT;
                        end else begin
                            next_s.scl_oe_n = 1'b0;
                            next_s.st = ST_HOLD;
                        end
                    end
                end
                ST_WAIT: begin
                    next_s.sda_oe_n = 1'b1;
                    next_s.scl_oe_n = 1'b1;
                end
                default: begin
                    next_s.st = ST_IDLE;
                    next_s.sda_oe_n = 1'b1;
                    next_s.scl_oe_n = 1'b1;
                end
            endcase

            // counter counts sub-clock, cleared by clock falling edge
            if (s.to_run) begin
                if (scl_fall) begin
                    next_s.to_cnt = 12'h000;
                end else if (sub_rise) begin
                    next_s.to_cnt = s.to_cnt + 12'h001;
                end
            end

            if (start_ev) begin
                next_s.ctrl1[`CTRL1_BUSY_BIT] = 1'b1;
                next_s.bit_cnt = 4'h0;
                next_s.shift = 8'h00;
                next_s.sda_oe_n = 1'b1;
                next_s.scl_oe_n = 1'b1;
                next_s.st = ST_ADDR;
            end else if (stop_ev) begin
                next_s.ctrl1[`CTRL1_BUSY_BIT] = 1'b0;
                next_s.sda_oe_n = 1'b1;
                next_s.scl_oe_n = 1'b1;
                next_s.to_run = 1'b0;
                next_s.st = ST_IDLE;
            end

            if (timeout_hit) begin
                next_s.to_run = 1'b0;
                next_s.toc[`TOC_EN_BIT] = 1'b0;
                next_s.toc[`TOC_FLAG_BIT] = 1'b1;
                next_s.ctrl0[`CTRL0_IRQ_FLAG_BIT] = 1'b1;
                // second control back to power-on values
                next_s.ctrl1 = `CTRL1_RESET;
                next_s.sda_oe_n = 1'b1;
                next_s.scl_oe_n = 1'b1;
                next_s.st = ST_IDLE;
            end

            // Disabled interface never touches the wires
            if (!if_en) begin
                next_s.st = ST_IDLE;
                next_s.sda_oe_n = 1'b1;
                next_s.scl_oe_n = 1'b1;
                next_s.to_run = 1'b0;
            end

            // one interrupt line for all sources
            next_s.irq_line = next_s.ctrl0[`CTRL0_IRQ_FLAG_BIT]
                && next_s.ctrl0[`CTRL0_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            s <= '{st: ST_IDLE, scl_prev: 1'b1, sda_prev: 1'b1, sub_prev: 1'b1,
                   bit_cnt: 4'h0, shift: 8'h00, ctrl0: `CTRL0_RESET, ctrl1: `CTRL1_RESET,
                   data: `DATA_RESET, own_addr: `OWN_ADDR_RESET, toc: `TOC_RESET,
                   to_run: 1'b0, to_cnt: 12'h000, irq_line: 1'b0, sda_oe_n: 1'b1,
                   scl_oe_n: 1'b1, pin_low: 1'b0, rdata: 8'h00};
        end else begin
            s <= next_s;
        end
    end

    assign RDATA_OUT = s.rdata;
    assign SCL_OUT = s.pin_low;
    assign SCL_OE_N_OUT = s.scl_oe_n;
    assign SDA_OUT = s.pin_low;
    assign SDA_OE_N_OUT = s.sda_oe_n;
    assign IRQ_OUT = s.irq_line;

    default clocking dc @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    a_busy_on_start: assert property (
        CE_IN && if_en && start_ev && !timeout_hit |=> s.ctrl1[`CTRL1_BUSY_BIT] && s.st == ST_ADDR)
        else $error("busy flag not set after start");

    a_busy_off_stop: assert property (
        CE_IN && stop_ev && !start_ev |=> !s.ctrl1[`CTRL1_BUSY_BIT] && s.st == ST_IDLE)
        else $error("busy flag not cleared after stop");

    a_match_sets_flag: assert property (
        CE_IN && if_en && s.st == ST_ADDR && scl_fall && s.bit_cnt == `BYTE_BITS && addr_hit
        && !timeout_hit |=> s.ctrl1[`CTRL1_MATCH_BIT] && s.ctrl0[`CTRL0_IRQ_FLAG_BIT]
        && s.st == ST_ADDR_ACK)
        else $error("address match not flagged");

    a_rw_capture: assert property (
        CE_IN && if_en && s.st == ST_ADDR && scl_fall && s.bit_cnt == `BYTE_BITS && addr_hit
        && !timeout_hit |=> s.ctrl1[`CTRL1_DIR_BIT] == $past(s.shift[0]))
        else $error("direction bit not captured");

    a_addr_ack_drive: assert property (
        s.st == ST_ADDR_ACK |-> !s.sda_oe_n && s.scl_oe_n)
        else $error("address acknowledge not driven");

    a_rx_byte_store: assert property (
        CE_IN && if_en && s.st == ST_RX && scl_fall && s.bit_cnt == `BYTE_BITS
        && !start_ev && !stop_ev && !timeout_hit
        |=> s.data == $past(s.shift) && s.ctrl1[`CTRL1_DONE_BIT])
        else $error("received byte not stored");

    a_rx_ack_level: assert property (
        CE_IN && if_en && s.st == ST_RX && scl_fall && s.bit_cnt == `BYTE_BITS
        && !start_ev && !stop_ev && !timeout_hit
        |=> s.sda_oe_n == $past(s.ctrl1[`CTRL1_ACKOUT_BIT]) && s.st == ST_RX_ACK)
        else $error("acknowledge level wrong");

    a_nack_release: assert property (
        s.st == ST_WAIT |-> s.sda_oe_n && s.scl_oe_n)
        else $error("data line held after no acknowledge");

    a_busy_clears_done: assert property (
        s.st == ST_RX || s.st == ST_TX |-> !s.ctrl1[`CTRL1_DONE_BIT])
        else $error("byte flag set during transfer");

    a_timeout_effects: assert property (
        CE_IN && timeout_hit |=> !s.toc[`TOC_EN_BIT] && s.toc[`TOC_FLAG_BIT] && !s.to_run
        && s.ctrl1 == `CTRL1_RESET && s.st == ST_IDLE)
        else $error("time-out effects missing");

    a_hold_stretch: assert property (
        s.st == ST_HOLD && !(CE_IN && (WR_IN || RD_IN || start_ev || stop_ev || timeout_hit))
        |=> s.st == ST_HOLD && !s.scl_oe_n)
        else $error("clock not held while waiting");

endmodule : i2c_slave

`default_nettype wire

/* File: i2c_master_model.sv */
// Behavioural two-wire bus master facing the slave
`default_nettype none

module i2c_master_model (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end

    // Bounded, so a stuck slave cannot hang the run
    task automatic wait_high();
        int n;
        n = 0;
        while (scl_in !== 1'b1 && n < 4000) begin
            #10;
            n++;
        end
    endtask : wait_high

    task automatic clock_bit(input logic b, output logic r);
        sda_out = b;
        #20;
        scl_out = 1'b1;
        wait_high();
        #40;
        r = sda_in;
        scl_out = 1'b0;
        #20;
    endtask : clock_bit

    task automatic start_cond();
        sda_out = 1'b1;
        #20;
        scl_out = 1'b1;
        wait_high();
        #40;
        sda_out = 1'b0;
        #40;
        scl_out = 1'b0;
        #20;
    endtask : start_cond

    task automatic stop_cond();
        sda_out = 1'b0;
        #20;
        scl_out = 1'b1;
        wait_high();
        #40;
        sda_out = 1'b1;
        #80;
    endtask : stop_cond

    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(d[i], r);
        end
        clock_bit(1'b1, ack);
        #60;
    endtask : byte_out

    task automatic byte_in(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, d[i]);
        end
        clock_bit(ack, r);
        #60;
    endtask : byte_in
endmodule : i2c_master_model

`default_nettype wire

/* File: i2c_slave_with_timeout_test.sv */
// Self-checking bench for the two-wire bus slave
`include "i2c_slave_map.svh"
`default_nettype none

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("BAD at %0t got %h expected %h", $time, (got), (exp)); \
        end \
    end

module i2c_slave_with_timeout_test;
    import i2c_slave_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0] own = 7'h5a;
    localparam logic [7:0] st_mask = 8'h64;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sub_clk = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, irq, m_scl, m_sda, ack;
    logic [7:0] d;
    wire scl_w;
    wire sda_w;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;

    // Pull-ups: released lines read high
    assign scl_w = m_scl & (scl_oe_n | scl_o);
    assign sda_w = m_sda & (sda_oe_n | sda_o);

    i2c_slave uut (
        .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .SCL_IN(scl_w), .SCL_OUT(scl_o), .SCL_OE_N_OUT(scl_oe_n),
        .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n),
        .SUB_CLK_IN(sub_clk), .IRQ_OUT(irq)
    );

    i2c_master_model m (.scl_in(scl_w), .sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));

    initial begin
        forever #5 clk = ~clk;
    end

    initial begin
        forever #80 sub_clk = ~sub_clk;
    end

    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, input logic [7:0] msk, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata & msk, e)
    endtask : rd_reg

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`OFS_CTRL0, 8'hff, `CTRL0_RESET);
        rd_reg(`OFS_CTRL1, 8'hff, `CTRL1_RESET);
        rd_reg(`OFS_DATA, 8'hff, `DATA_RESET);
        rd_reg(`OFS_OWN_ADDR, 8'hff, `OWN_ADDR_RESET);
        rd_reg(`OFS_TIMEOUT, 8'hff, `TOC_RESET);
        wr_reg(3'h7, 8'hff);
        rd_reg(3'h5, 8'hff, 8'h00);
        wr_reg(`OFS_CTRL1, 8'hff);
        rd_reg(`OFS_CTRL1, 8'hff, `CTRL1_RESET | `CTRL1_WMASK);
        wr_reg(`OFS_CTRL1, 8'h00);
        wr_reg(`OFS_CTRL0, 8'h02);
        wr_reg(`OFS_OWN_ADDR, {own, 1'b0});
        wr_reg(`OFS_CTRL0, 8'h03);
        rd_reg(`OFS_OWN_ADDR, 8'hff, {own, 1'b0});
        // Calling address differs only in its last bit
        m.start_cond();
        m.byte_out({own ^ 7'h01, 1'b0}, ack);
        `CHK(ack, 1'b1)
        rd_reg(`OFS_CTRL1, st_mask, 8'h20);
        `CHK(irq, 1'b0)
        m.stop_cond();
        rd_reg(`OFS_CTRL1, st_mask, 8'h00);
        // Master writes two bytes, second one refused
        m.start_cond();
        m.byte_out({own, 1'b0}, ack);
        `CHK(ack, 1'b0)
        `CHK(irq, 1'b1)
        `CHK(scl_oe_n, 1'b0)
        rd_reg(`OFS_CTRL1, st_mask, 8'h60);
        wr_reg(`OFS_CTRL0, 8'h03);
        rd_reg(`OFS_DATA, 8'hff, `DATA_RESET);
        m.byte_out(8'ha7, ack);
        `CHK(ack, 1'b0)
        `CHK(irq, 1'b1)
        rd_reg(`OFS_CTRL1, 8'h80, 8'h80);
        wr_reg(`OFS_CTRL1, 8'h08);
        rd_reg(`OFS_DATA, 8'hff, 8'ha7);
        m.byte_out(8'h3c, ack);
        `CHK(ack, 1'b1)
        rd_reg(`OFS_DATA, 8'hff, 8'h3c);
        wr_reg(`OFS_CTRL1, 8'h00);
        m.stop_cond();
        // Master reads two bytes, refusing the last
        wr_reg(`OFS_CTRL0, 8'h03);
        m.start_cond();
        m.byte_out({own, 1'b1}, ack);
        rd_reg(`OFS_CTRL1, st_mask, 8'h64);
        wr_reg(`OFS_CTRL1, 8'h10);
        wr_reg(`OFS_DATA, 8'hc3);
        m.byte_in(1'b0, d);
        `CHK(d, 8'hc3)
        rd_reg(`OFS_CTRL1, 8'h81, 8'h80);
        wr_reg(`OFS_DATA, 8'h5e);
        m.byte_in(1'b1, d);
        `CHK(d, 8'h5e)
        rd_reg(`OFS_CTRL1, 8'h01, 8'h01);
        `CHK(sda_oe_n, 1'b1)
        m.stop_cond();
        wr_reg(`OFS_CTRL1, 8'h00);
        // Master stalls after a match with select one
        wr_reg(`OFS_CTRL0, 8'h03);
        wr_reg(`OFS_DATA, 8'h96);
        wr_reg(`OFS_TIMEOUT, 8'h81);
        m.start_cond();
        m.byte_out({own, 1'b0}, ack);
        repeat (60) @(posedge sub_clk);
        rd_reg(`OFS_TIMEOUT, 8'hff, 8'h81);
        repeat (8) @(posedge sub_clk);
        rd_reg(`OFS_TIMEOUT, 8'hff, 8'h41);
        rd_reg(`OFS_CTRL1, 8'hff, `CTRL1_RESET);
        rd_reg(`OFS_DATA, 8'hff, 8'h96);
        rd_reg(`OFS_OWN_ADDR, 8'hff, {own, 1'b0});
        rd_reg(`OFS_CTRL0, 8'hff, 8'h07);
        `CHK(scl_oe_n, 1'b1)
        `CHK(irq, 1'b1)
        m.stop_cond();
        rd_reg(`OFS_TIMEOUT, 8'hff, 8'h41);
        wr_reg(`OFS_TIMEOUT, 8'h00);
        rd_reg(`OFS_TIMEOUT, 8'hff, 8'h00);
        wrap_up();
    end
endmodule : i2c_slave_with_timeout_test

`default_nettype wire
